// file: inc/afe_defs.vh
`ifndef AFE_DEFS_VH
`define AFE_DEFS_VH
// register write command: opcode in the top three bits, address in the next five bits
`define AFE_CMD_WRITE         3'h2
`define AFE_ADDR_FIRST_SETUP  5'h01
`define AFE_ADDR_THIRD_SETUP  5'h03
`define AFE_ADDR_EOFF_CTRL    5'h04
`define AFE_ADDR_CH4_SET      5'h08
`define AFE_ADDR_CH5_SET      5'h09
`define AFE_ADDR_LD_POS_SENSE 5'h0D
`define AFE_ADDR_LD_NEG_SENSE 5'h0E
`define AFE_ADDR_EOFF_POS     5'h0F
`define AFE_ADDR_EOFF_NEG     5'h10
`define AFE_ADDR_PACE         5'h15
`define AFE_ADDR_FOURTH_SETUP 5'h17
// field positions
`define AFE_EOFF_THR_HI       7
`define AFE_EOFF_THR_LO       5
`define AFE_EOFF_MODE_BIT     4
`define AFE_C3_PWR_LD         2
`define AFE_C3_REF_INT        3
`define AFE_C3_MEAS_LD        4
`define AFE_C3_NIB_OK         4'hC
`define AFE_C3_BIT6           6
`define AFE_C4_COMP_ON        1
`define AFE_CH_PD_BIT         7
`define AFE_MUX_LD_TO_NEG     4'h7
`define AFE_MUX_LD_MEAS       4'h2
`define AFE_PACE_PWR_BIT      0
`define AFE_PACE_SEL_HI       4
`define AFE_PACE_SEL_LO       1
// reset values
`define AFE_RST_THIRD_SETUP   8'h40
`define AFE_RST_OTHER         8'h00
// power-up timing in master clock periods
`define AFE_POR_LOG2          16
`define AFE_RST_MIN_CLK       2
`endif

// file: hw/afe_reg_shift.v
`timescale 1ns/100ps
`include "afe_defs.vh"
// serial word assembler: 16-bit command words, MSB first, framed by csActiveN
module afe_reg_shift #(
  parameter WIDTH = 16
) (
  input  wire             sys_clk,
  input  wire             srst,
  input  wire             csActiveN,
  input  wire             sclkRise,
  input  wire             sdIn,
  output reg              wordValid,
  output reg  [WIDTH-1:0] wordData
);
  reg [WIDTH-1:0] shift_reg;
  reg [4:0]       count_reg;

  // bits collected only inside a frame; frame end discards a partial word
  always @(posedge sys_clk) begin
    wordValid <= 1'b0;
    if (srst || csActiveN) begin
      count_reg <= 5'h00;
      shift_reg <= {WIDTH{1'b0}};
    end else if (sclkRise) begin
      shift_reg <= {shift_reg[WIDTH-2:0], sdIn};
      if (count_reg == WIDTH - 1) begin
        count_reg <= 5'h00;
        wordValid <= 1'b1;
        wordData  <= {shift_reg[WIDTH-2:0], sdIn};
      end else begin
        count_reg <= count_reg + 5'h01;
      end
    end
  end
endmodule // afe_reg_shift

// file: hw/afe_por_timer.v
`timescale 1ns/100ps
`include "afe_defs.vh"
// counts master clock periods since srst and checks reset pulse width
module afe_por_timer #(
  parameter POR_CYCLES = 65536,
  parameter RST_CYCLES = 2
) (
  input  wire sys_clk,
  input  wire srst,
  input  wire resetInN,
  output reg  porDone,
  output reg  resetTaken,
  output reg  seqError
);
  reg [16:0] porCnt_reg;
  reg [3:0]  lowCnt_reg;

  // early or short reset pulses are flagged, never silently accepted
  always @(posedge sys_clk) begin
    resetTaken <= 1'b0;
    if (srst) begin
      porCnt_reg <= 17'h00000;
      lowCnt_reg <= 4'h0;
      porDone    <= 1'b0;
      seqError   <= 1'b0;
    end else begin
      if (!porDone) begin
        porCnt_reg <= porCnt_reg + 17'h00001;
        if (porCnt_reg == POR_CYCLES - 1)
          porDone <= 1'b1;
      end
      if (!resetInN) begin
        if (lowCnt_reg != 4'hF)
          lowCnt_reg <= lowCnt_reg + 4'h1;
        if (!porDone)
          seqError <= 1'b1;
      end else begin
        lowCnt_reg <= 4'h0;
        if (lowCnt_reg != 4'h0) begin
          if (lowCnt_reg >= RST_CYCLES)
            resetTaken <= 1'b1;
          else
            seqError <= 1'b1;
        end
      end
    end
  end
endmodule // afe_por_timer

// file: hw/afe_setup_core.v
`timescale 1ns/100ps
`include "afe_defs.vh"
module afe_setup_core #(
  parameter POR_CYCLES = 65536,
  parameter RST_CYCLES = `AFE_RST_MIN_CLK,
  parameter CH_COUNT   = 8
) (
  input  wire                sys_clk,
  input  wire                srst,
  input  wire                resetInN,
  input  wire                csActiveN,
  input  wire                sclkIn,
  input  wire                sdIn,
  input  wire [CH_COUNT-1:0] posAboveHi,
  input  wire [CH_COUNT-1:0] negBelowLo,
  output reg                 deviceReady,
  output reg                 convTrusted,
  output reg                 seqError,
  output reg  [2:0]          compThreshold,
  output reg                 dcResistorMode,
  output reg                 compEnable,
  output reg  [CH_COUNT-1:0] posSenseEnable,
  output reg  [CH_COUNT-1:0] negSenseEnable,
  output reg  [CH_COUNT-1:0] legDrivePosSel,
  output reg  [CH_COUNT-1:0] legDriveNegSel,
  output reg                 legDriveAmpOn,
  output reg                 legDriveRefInternal,
  output reg                 legDriveMeasure,
  output reg                 ch4LegDriveToNeg,
  output reg                 ch5LegDriveMeasure,
  output reg                 pacingAmpPowerdown,
  output reg  [1:0]          paceOddSel,
  output reg  [1:0]          paceEvenSel,
  output reg  [15:0]         statusWord
);
  ////////////////////////////////////////////////////////////////////////
  // serial clock edge detect and word assembly
  reg             sclkLast_reg;
  wire            sclkRise = sclkIn & ~sclkLast_reg;
  wire            wordValid;
  wire [15:0]     wordData;
  wire            porDone;
  wire            resetTaken;
  wire            timerError;

  always @(posedge sys_clk) begin
    if (srst)
      sclkLast_reg <= 1'b0;
    else
      sclkLast_reg <= sclkIn;
  end

  afe_reg_shift #(
    .WIDTH     (16)
  ) u_shift (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .csActiveN (csActiveN),
    .sclkRise  (sclkRise),
    .sdIn      (sdIn),
    .wordValid (wordValid),
    .wordData  (wordData)
  );

  // watches the host's clock-start wait and reset pulse width
  afe_por_timer #(
    .POR_CYCLES (POR_CYCLES),
    .RST_CYCLES (RST_CYCLES)
  ) u_por (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .resetInN   (resetInN),
    .porDone    (porDone),
    .resetTaken (resetTaken),
    .seqError   (timerError)
  );

  ////////////////////////////////////////////////////////////////////////
  // register storage
  reg [7:0] firstSetup_reg;
  reg [7:0] thirdSetup_reg;
  reg [7:0] fourthSetup_reg;
  reg [7:0] eoffCtrl_reg;
  reg [7:0] eoffPos_reg;
  reg [7:0] eoffNeg_reg;
  reg [7:0] ldPos_reg;
  reg [7:0] ldNeg_reg;
  reg [7:0] channel_four_settings_reg_reg;
  reg [7:0] channel_five_settings_reg_reg;
  reg [7:0] pace_reg;
  reg       resetSeen_reg;
  reg       firstWritten_reg;

  wire       isWrite = wordValid && (wordData[15:13] == `AFE_CMD_WRITE) && resetSeen_reg;
  wire [4:0] wAddr   = wordData[12:8];
  wire [7:0] wData   = wordData[7:0];

  // writes only count once a valid reset pulse has been seen
  always @(posedge sys_clk) begin
    if (srst || resetTaken) begin
      firstSetup_reg   <= `AFE_RST_OTHER;
      thirdSetup_reg   <= `AFE_RST_THIRD_SETUP;
      fourthSetup_reg  <= `AFE_RST_OTHER;
      eoffCtrl_reg     <= `AFE_RST_OTHER;
      eoffPos_reg      <= `AFE_RST_OTHER;
      eoffNeg_reg      <= `AFE_RST_OTHER;
      ldPos_reg        <= `AFE_RST_OTHER;
      ldNeg_reg        <= `AFE_RST_OTHER;
      channel_four_settings_reg_reg       <= `AFE_RST_OTHER;
      channel_five_settings_reg_reg       <= `AFE_RST_OTHER;
      pace_reg         <= `AFE_RST_OTHER;
      firstWritten_reg <= 1'b0;
      resetSeen_reg    <= resetTaken;
    end else if (isWrite) begin
      if (wAddr == `AFE_ADDR_FIRST_SETUP) begin
        firstSetup_reg   <= wData;
        firstWritten_reg <= 1'b1;
      end else if (wAddr == `AFE_ADDR_THIRD_SETUP) begin
        thirdSetup_reg <= wData;
      end else if (wAddr == `AFE_ADDR_FOURTH_SETUP) begin
        fourthSetup_reg <= wData;
      end else if (wAddr == `AFE_ADDR_EOFF_CTRL) begin
        eoffCtrl_reg <= wData;
      end else if (wAddr == `AFE_ADDR_EOFF_POS) begin
        eoffPos_reg <= wData;
      end else if (wAddr == `AFE_ADDR_EOFF_NEG) begin
        eoffNeg_reg <= wData;
      end else if (wAddr == `AFE_ADDR_LD_POS_SENSE) begin
        ldPos_reg <= wData;
      end else if (wAddr == `AFE_ADDR_LD_NEG_SENSE) begin
        ldNeg_reg <= wData;
      end else if (wAddr == `AFE_ADDR_CH4_SET) begin
        channel_four_settings_reg_reg <= wData;
      end else if (wAddr == `AFE_ADDR_CH5_SET) begin
        channel_five_settings_reg_reg <= wData;
      end else if (wAddr == `AFE_ADDR_PACE) begin
        pace_reg <= wData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode helpers
  function nibbleOk;
    input [7:0] v;
    begin
      nibbleOk = (v[3:0] == `AFE_C3_NIB_OK);
    end
  endfunction

  function [CH_COUNT-1:0] widen;
    input [7:0] v;
    begin
      widen = v[CH_COUNT-1:0];
    end
  endfunction

  wire [CH_COUNT-1:0] posOff = posAboveHi & posSenseEnable;
  wire [CH_COUNT-1:0] negOff = negBelowLo & negSenseEnable;

  ////////////////////////////////////////////////////////////////////////
  // registered control outputs; every output straight from a flip-flop
  always @(posedge sys_clk) begin
    if (srst) begin
      deviceReady         <= 1'b0;
      convTrusted         <= 1'b0;
      seqError            <= 1'b0;
      compThreshold       <= 3'h0;
      dcResistorMode      <= 1'b0;
      compEnable          <= 1'b0;
      posSenseEnable      <= {CH_COUNT{1'b0}};
      negSenseEnable      <= {CH_COUNT{1'b0}};
      legDrivePosSel      <= {CH_COUNT{1'b0}};
      legDriveNegSel      <= {CH_COUNT{1'b0}};
      legDriveAmpOn       <= 1'b0;
      legDriveRefInternal <= 1'b0;
      legDriveMeasure     <= 1'b0;
      ch4LegDriveToNeg    <= 1'b0;
      ch5LegDriveMeasure  <= 1'b0;
      pacingAmpPowerdown  <= 1'b1;
      paceOddSel          <= 2'h0;
      paceEvenSel         <= 2'h0;
      statusWord          <= 16'h0000;
    end else begin
      deviceReady <= porDone;
      convTrusted <= resetSeen_reg && firstWritten_reg;
      // sticky until srst, so a one-cycle early word is not lost
      seqError    <= seqError | timerError | (wordValid && !resetSeen_reg);
      // threshold field drives only the compThreshold output
      compThreshold  <= eoffCtrl_reg[`AFE_EOFF_THR_HI:`AFE_EOFF_THR_LO];
      dcResistorMode <= eoffCtrl_reg[`AFE_EOFF_MODE_BIT];
      compEnable     <= fourthSetup_reg[`AFE_C4_COMP_ON];
      posSenseEnable <= widen(eoffPos_reg);
      negSenseEnable <= widen(eoffNeg_reg);
      legDrivePosSel <= widen(ldPos_reg);
      legDriveNegSel <= widen(ldNeg_reg);
      // amp is only on with the full nibble pattern, not a stray bit
      legDriveAmpOn       <= nibbleOk(thirdSetup_reg) && thirdSetup_reg[`AFE_C3_BIT6];
      legDriveRefInternal <= thirdSetup_reg[`AFE_C3_REF_INT];
      legDriveMeasure     <= nibbleOk(thirdSetup_reg) && thirdSetup_reg[`AFE_C3_MEAS_LD];
      ch4LegDriveToNeg    <= channel_four_settings_reg_reg[`AFE_CH_PD_BIT] && (channel_four_settings_reg_reg[3:0] == `AFE_MUX_LD_TO_NEG);
      ch5LegDriveMeasure  <= (channel_five_settings_reg_reg[3:0] == `AFE_MUX_LD_MEAS);
      // pace: bit 0 high powers the amps; 0x15 gives ch5 odd, ch6 even
      pacingAmpPowerdown  <= ~pace_reg[`AFE_PACE_PWR_BIT];
      paceEvenSel         <= pace_reg[4:3];
      paceOddSel          <= pace_reg[2:1];
      // status: 4-bit marker, then positive and negative electrode-off flags
      statusWord <= {4'hC, posOff[7:0] & {8{compEnable}}, negOff[3:0] & {4{compEnable}}};
    end
  end
endmodule // afe_setup_core

// file: verification/afe_setup_properties.sv
`timescale 1ns/100ps
// watches the setup core from its ports only
module afe_setup_properties #(
  parameter POR_CYCLES = 65536
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        resetInN,
  input wire logic        csActiveN,
  input wire logic        deviceReady,
  input wire logic        convTrusted,
  input wire logic        seqError,
  input wire logic [2:0]  compThreshold,
  input wire logic        compEnable,
  input wire logic [7:0]  posSenseEnable,
  input wire logic [7:0]  negSenseEnable,
  input wire logic        legDriveAmpOn,
  input wire logic        legDriveRefInternal,
  input wire logic        pacingAmpPowerdown,
  input wire logic [15:0] statusWord
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [16:0] porCnt_reg;
  logic [3:0]  quietCnt_reg;
  ////////////////////////////////////////////////////////////
  // cycles since srst, and cycles with no frame or reset pin activity
  always @(posedge sys_clk) begin
    if (srst) porCnt_reg <= 17'h00000;
    else if (porCnt_reg != 17'h1FFFF) porCnt_reg <= porCnt_reg + 17'h00001;
    if (srst || !csActiveN || !resetInN) quietCnt_reg <= 4'h0;
    else if (quietCnt_reg != 4'hF) quietCnt_reg <= quietCnt_reg + 4'h1;
  end
  reset_values_a: assert property ($past(srst) |-> pacingAmpPowerdown && !compEnable && !deviceReady)
    else $error("outputs not at reset values after srst");
  por_wait_a: assert property (deviceReady |-> porCnt_reg >= POR_CYCLES - 2)
    else $error("ready before power-on wait");
  por_done_a: assert property (porCnt_reg == POR_CYCLES + 4 |-> deviceReady)
    else $error("ready missing after power-on wait");
  error_sticky_a: assert property (seqError |=> seqError)
    else $error("sequence error cleared without srst");
  trust_ready_a: assert property ($rose(convTrusted) |-> deviceReady)
    else $error("conversions trusted before power-on wait");
  config_idle_a: assert property (quietCnt_reg >= 6 |-> $stable(compThreshold) && $stable(compEnable)
    && $stable(posSenseEnable) && $stable(negSenseEnable) && $stable(pacingAmpPowerdown))
    else $error("setup output moved without a write");
  amp_ref_a: assert property (legDriveAmpOn |-> legDriveRefInternal)
    else $error("leg-drive amp on without internal reference");
  status_tag_a: assert property (porCnt_reg >= 4 && quietCnt_reg >= 6 |-> statusWord[15:12] == 4'hC)
    else $error("status word tag wrong");
endmodule // afe_setup_properties

// file: verification/afe_host_model.sv
`timescale 1ns/100ps
// host side: reset pin and serial writes, all driven on the falling edge
module afe_host_model (
  input wire logic sys_clk,
  output logic     resetInN,
  output logic     csActiveN,
  output logic     sclkIn,
  output logic     sdIn
);
  // idle: serial clock parked low, nothing selected
  initial begin
    resetInN = 1'b1;
    csActiveN = 1'b1;
    sclkIn = 1'b0;
    sdIn = 1'b0;
  end
  // one single low pulse on the reset pin
  task automatic pulse_reset(input int lowCycles);
    @(negedge sys_clk) resetInN = 1'b0;
    repeat (lowCycles) @(negedge sys_clk);
    resetInN = 1'b1;
  endtask
  // sixteen bits msb first, each clock phase two system cycles wide
  task automatic send_word(input logic [15:0] word);
    @(negedge sys_clk) csActiveN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdIn = word[i];
      repeat (2) @(negedge sys_clk);
      sclkIn = 1'b1;
      repeat (2) @(negedge sys_clk);
      sclkIn = 1'b0;
    end
    repeat (2) @(negedge sys_clk);
    csActiveN = 1'b1;
    sdIn = ~sdIn; // released line must not keep the last bit
  endtask
endmodule // afe_host_model

// file: verification/tb.sv
`timescale 1ns/100ps
`include "afe_defs.vh"
module tb;
  logic        sys_clk, srst, resetInN, csActiveN, sclkIn, sdIn;
  logic [7:0]  posAboveHi, negBelowLo, posSenseEnable, negSenseEnable, legDrivePosSel, legDriveNegSel, v;
  logic        deviceReady, convTrusted, seqError, dcResistorMode, compEnable, legDriveAmpOn;
  logic        legDriveRefInternal, legDriveMeasure, ch4LegDriveToNeg, ch5LegDriveMeasure, pacingAmpPowerdown;
  logic [2:0]  compThreshold;
  logic [1:0]  paceOddSel, paceEvenSel;
  logic [15:0] statusWord;
  logic [7:0]  c3Tab [5];
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycleCnt = 0;
  afe_setup_core #(.POR_CYCLES(64)) dut (.sys_clk, .srst, .resetInN, .csActiveN, .sclkIn, .sdIn, .posAboveHi,
    .negBelowLo, .deviceReady, .convTrusted, .seqError, .compThreshold, .dcResistorMode, .compEnable,
    .posSenseEnable, .negSenseEnable, .legDrivePosSel, .legDriveNegSel, .legDriveAmpOn, .legDriveRefInternal,
    .legDriveMeasure, .ch4LegDriveToNeg, .ch5LegDriveMeasure, .pacingAmpPowerdown, .paceOddSel, .paceEvenSel,
    .statusWord);
  afe_host_model host (.sys_clk, .resetInN, .csActiveN, .sclkIn, .sdIn);
  ////////////////////////////////////////////////////////////
  // clock runs from time zero, before any host activity
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // hang guard, well above the few thousand cycles needed
  always @(posedge sys_clk) begin
    cycleCnt++;
    if (cycleCnt == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // write then let the three-edge update land
  task automatic wr(input logic [4:0] addr, input logic [7:0] data);
    host.send_word({`AFE_CMD_WRITE, addr, data});
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic give_verdict();
    $display("%0d comparisons, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // reference select, measure and amp-on expected from a third setup value
  function automatic logic [2:0] rld_exp(input logic [7:0] c);
    return {c[`AFE_C3_REF_INT], c[3:0] == `AFE_C3_NIB_OK && c[4], c[3:0] == `AFE_C3_NIB_OK && c[6]};
  endfunction
  initial begin
    srst = 1'b1;
    posAboveHi = 8'h00;
    negBelowLo = 8'h00;
    void'($urandom(22));
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    wr(`AFE_ADDR_FOURTH_SETUP, 8'h02);
    chk({seqError, compEnable}, 2'b10, "write before reset pulse");
    done("early write");
    srst = 1'b1;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    for (int i = 0; i < 200 && deviceReady !== 1'b1; i++) @(negedge sys_clk);
    chk(deviceReady, 1'b1, "power-on wait");
    repeat (10) @(negedge sys_clk);
    host.pulse_reset(2);
    repeat (4) @(negedge sys_clk);
    chk({seqError, convTrusted, pacingAmpPowerdown, compEnable}, 4'b0010, "after reset pulse");
    wr(`AFE_ADDR_FIRST_SETUP, 8'($urandom));
    chk(convTrusted, 1'b1, "first setup written");
    done("power-up");
    wr(`AFE_ADDR_EOFF_CTRL, 8'h13);
    chk({compThreshold, dcResistorMode}, 4'b0001, "threshold 95/5 resistor");
    wr(`AFE_ADDR_FOURTH_SETUP, 8'h02);
    chk(compEnable, 1'b1, "comparators on");
    wr(`AFE_ADDR_EOFF_POS, 8'hFF);
    wr(`AFE_ADDR_EOFF_NEG, 8'hFF);
    chk({posSenseEnable, negSenseEnable}, 16'hFFFF, "sense all inputs");
    repeat (8) begin
      posAboveHi = 8'($urandom);
      negBelowLo = 8'($urandom);
      repeat (4) @(negedge sys_clk);
      chk(statusWord, {4'hC, posAboveHi, negBelowLo[3:0]}, "status bits");
    end
    repeat (6) begin
      v = 8'($urandom);
      wr(`AFE_ADDR_EOFF_CTRL, v);
      chk({compThreshold, dcResistorMode}, {v[7:5], v[4]}, "threshold field");
    end
    wr(5'h1F, ~v);
    chk({compThreshold, dcResistorMode}, {v[7:5], v[4]}, "unmapped write ignored");
    done("electrode-off");
    wr(`AFE_ADDR_LD_POS_SENSE, 8'h07);
    wr(`AFE_ADDR_LD_NEG_SENSE, 8'h07);
    chk({legDrivePosSel, legDriveNegSel}, 16'h0707, "leg-drive channels 1-3");
    c3Tab = '{8'h4C, 8'h1C, 8'h5C, 8'h48, 8'($urandom)};
    foreach (c3Tab[i]) begin
      wr(`AFE_ADDR_THIRD_SETUP, c3Tab[i]);
      chk({legDriveRefInternal, legDriveMeasure, legDriveAmpOn}, rld_exp(c3Tab[i]), "leg-drive amp");
    end
    wr(`AFE_ADDR_CH4_SET, 8'h87);
    chk(ch4LegDriveToNeg, 1'b1, "ch4 routed");
    wr(`AFE_ADDR_CH4_SET, 8'h07);
    chk(ch4LegDriveToNeg, 1'b0, "ch4 powered");
    wr(`AFE_ADDR_CH5_SET, 8'h82);
    chk(ch5LegDriveMeasure, 1'b1, "ch5 measures");
    wr(`AFE_ADDR_CH5_SET, 8'h85);
    chk(ch5LegDriveMeasure, 1'b0, "ch5 other mux");
    done("leg-drive");
    wr(`AFE_ADDR_PACE, 8'h15);
    chk({pacingAmpPowerdown, paceEvenSel, paceOddSel}, 5'b01010, "pace 5 and 6");
    repeat (6) begin
      v = 8'($urandom);
      wr(`AFE_ADDR_PACE, v);
      chk({pacingAmpPowerdown, paceEvenSel, paceOddSel}, {~v[0], v[4:3], v[2:1]}, "pace field");
    end
    done("pace");
    host.pulse_reset(1);
    repeat (4) @(negedge sys_clk);
    chk(seqError, 1'b1, "short reset pulse flagged");
    done("short reset");
    give_verdict();
  end
endmodule // tb
bind afe_setup_core afe_setup_properties #(.POR_CYCLES(POR_CYCLES)) props (.sys_clk, .srst, .resetInN,
  .csActiveN, .deviceReady, .convTrusted, .seqError, .compThreshold, .compEnable, .posSenseEnable,
  .negSenseEnable, .legDriveAmpOn, .legDriveRefInternal, .pacingAmpPowerdown, .statusWord);
